/* pkg/mode_select_regs.vh */
// register offsets, field positions and reset values of the mode select bank
`ifndef MODE_SELECT_REGS_VH
`define MODE_SELECT_REGS_VH

`define OFS_OPERATING_MODE_SELECT  8'h03
`define OFS_BACK_CHANNEL_VIDEO     8'h04

// operating_mode_select fields
`define FLD_MODE_RSV7_BIT          7
`define FLD_MODE_STRAP6_BIT        6
`define FLD_MODE_RSV5_BIT          5
`define FLD_STRAP_OVERRIDE_BIT     4
`define FLD_MODE_DONE_BIT          3
`define FLD_MODE_MSB               2
`define FLD_MODE_LSB               0

// back_channel_video_mode fields
`define FLD_VIDEO_RSV_MSB          7
`define FLD_VIDEO_RSV_LSB          3
`define FLD_RAW10_BIT              2
`define FLD_RAW12_BIT              1
`define FLD_AUTOLOAD_BLOCK_BIT     0

`define RST_MODE_CTRL              8'h00
`define RST_VIDEO_MODE             8'h00

// mode encodings
`define MODE_CSI_SYNC              3'h0
`define MODE_RESERVED_1            3'h1
`define MODE_CSI_NONSYNC_EXT       3'h2
`define MODE_CSI_NONSYNC_AON       3'h3
`define MODE_VIDEO_EXT_CLK         3'h5

// cycles the strap must hold steady before the capture counts as settled
`define MODE_SETTLE_CYCLES         4'h8

`endif

/* logic/pin_sync3.v */
// three-stage synchroniser with agreement filter for asynchronous pins
`default_nettype none

module pin_sync3 #(
  parameter       WIDTH = 1,
  parameter [0:0] INIT  = 1'b0
) (
  input  wire             clk_sys,
  input  wire             reset,
  input  wire [WIDTH-1:0] pin_in,
  output reg  [WIDTH-1:0] pin_out
);

  reg [WIDTH-1:0] s1_q;
  reg [WIDTH-1:0] s2_q;
  reg [WIDTH-1:0] s3_q;

  // s1 feeds only s2; the output moves once s2 and s3 agree
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
          s1_q[i]    <= INIT;
          s2_q[i]    <= INIT;
          s3_q[i]    <= INIT;
          pin_out[i] <= INIT;
        end else begin
          s1_q[i] <= pin_in[i];
          s2_q[i] <= s1_q[i];
          s3_q[i] <= s2_q[i];
          if (s2_q[i] == s3_q[i]) begin
            pin_out[i] <= s3_q[i];
          end
        end
      end
    end
  endgenerate

endmodule // pin_sync3

`default_nettype wire

/* logic/serializer_mode_select.v */
// operating mode and back-channel video mode register bank
`include "mode_select_regs.vh"
`default_nettype none

// What this block does
// R1: override bit 0 uses strapped mode; 1 uses register mode value.
// R2: read-only bit 3 flags that the selected mode settled and was latched.
// R3: mode field reads current mode; ignores writes while override is 0.
// R4: with override 1, writes to mode field become the operating mode.
// R5: strapped mode captured on rising edge of active-low powerdown input.
// R6: mode codes: 000 sync, 001 reserved, 010 ext clk, 011 aon, 101 video.
// R7: system supplies local clock for modes 010 and 101.
// R8: bit 2 selects raw10 video; control channel loads it after lock.
// R9: bit 1 selects raw12 video; control channel loads it after lock.
// R10: bit 0 set stops control channel autoloading the video mode bits.
// R11: software writing video bits also sets the autoload block bit; the code loads that bit from written bit 0 instead.
// R12: mode codes 100, 110 and 111 are reserved, no defined operation.
module serializer_mode_select (
  input  wire       clk_sys,
  input  wire       reset,
  input  wire       powerdown_n_input,
  input  wire [2:0] mode_strap_pin,
  input  wire       mode_strap_bit6_pin,
  input  wire       reg_wr_en,
  input  wire       reg_rd_en,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata,
  output reg        reg_rvalid,
  input  wire       rx_lock,
  input  wire       bcc_video_valid,
  input  wire       bcc_raw10,
  input  wire       bcc_raw12,
  output reg  [2:0] operating_mode,
  output reg        mode_done,
  output reg        mode_reserved,
  output reg        local_clock_required,
  output reg        raw10_video_select,
  output reg        raw12_video_select
);

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  wire       pdn_sync;
  wire [3:0] strap_sync;

  pin_sync3 #(
    .WIDTH (1),
    .INIT  (1'b0)
  ) u_pdn_sync (
    .clk_sys (clk_sys),
    .reset   (reset),
    .pin_in  (powerdown_n_input),
    .pin_out (pdn_sync)
  );

  pin_sync3 #(
    .WIDTH (4),
    .INIT  (1'b0)
  ) u_strap_sync (
    .clk_sys (clk_sys),
    .reset   (reset),
    .pin_in  ({mode_strap_bit6_pin, mode_strap_pin}),
    .pin_out (strap_sync)
  );

  // ------------------------------------------------------------
  // strap capture and settle
  // ------------------------------------------------------------
  localparam [2:0] ST_DOWN   = 3'b001;
  localparam [2:0] ST_SETTLE = 3'b010;
  localparam [2:0] ST_DONE   = 3'b100;

  reg [2:0] state_q;
  reg [2:0] state_d;
  reg       pdn_prev_q;
  reg [3:0] settle_q;
  reg [2:0] strap_mode_q;
  reg       strap_bit6_q;
  reg       done_q;

  wire pdn_rise = pdn_sync & ~pdn_prev_q;

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_DOWN: begin
        if (pdn_rise) begin
          state_d = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        if (!pdn_sync) begin
          state_d = ST_DOWN;
        end else if (settle_q == `MODE_SETTLE_CYCLES) begin
          state_d = ST_DONE;
        end
      end
      ST_DONE: begin
        if (!pdn_sync) begin
          state_d = ST_DOWN;
        end
      end
      default: state_d = ST_DOWN;
    endcase
  end

  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_q      <= ST_DOWN;
      pdn_prev_q   <= 1'b0;
      settle_q     <= 4'h0;
      strap_mode_q <= 3'h0;
      strap_bit6_q <= 1'b0;
      done_q       <= 1'b0;
    end else begin
      state_q    <= state_d;
      pdn_prev_q <= pdn_sync;
      if (pdn_rise) begin
        strap_mode_q <= strap_sync[2:0]; // R5
        strap_bit6_q <= strap_sync[3];
        settle_q     <= 4'h0;
      end else if (state_q == ST_SETTLE) begin
        // strap must hold its latched value through the settle window
        if (strap_sync[2:0] != strap_mode_q) begin
          strap_mode_q <= strap_sync[2:0];
          settle_q     <= 4'h0;
        end else begin
          settle_q <= settle_q + 4'h1;
        end
      end
      done_q <= (state_d == ST_DONE); // R2
    end
  end

  // ------------------------------------------------------------
  // register bank
  // ------------------------------------------------------------
  reg       ctl_rsv7_q;
  reg       ctl_rsv5_q;
  reg       override_q;
  reg [2:0] reg_mode_q;
  reg [4:0] video_rsv_q;
  reg       raw10_q;
  reg       raw12_q;
  reg       autoload_block_q;

  localparam [7:0] MODE_RST  = `RST_MODE_CTRL;
  localparam [7:0] VIDEO_RST = `RST_VIDEO_MODE;

  wire wr_mode  = reg_wr_en & (reg_addr == `OFS_OPERATING_MODE_SELECT);
  wire wr_video = reg_wr_en & (reg_addr == `OFS_BACK_CHANNEL_VIDEO);

  // one-cycle lock edge: each new lock triggers at most one autoload
  reg  lock_prev_q;
  reg  load_pending_q;
  wire lock_rise = rx_lock & ~lock_prev_q;
  wire autoload  = (load_pending_q | lock_rise) & bcc_video_valid
                   & rx_lock & ~autoload_block_q; // R10

  wire [2:0] cur_mode = override_q ? reg_mode_q : strap_mode_q; // R1

  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ctl_rsv7_q       <= MODE_RST[`FLD_MODE_RSV7_BIT];
      ctl_rsv5_q       <= MODE_RST[`FLD_MODE_RSV5_BIT];
      override_q       <= MODE_RST[`FLD_STRAP_OVERRIDE_BIT];
      reg_mode_q       <= MODE_RST[`FLD_MODE_MSB:`FLD_MODE_LSB];
      video_rsv_q      <= VIDEO_RST[`FLD_VIDEO_RSV_MSB:`FLD_VIDEO_RSV_LSB];
      raw10_q          <= VIDEO_RST[`FLD_RAW10_BIT];
      raw12_q          <= VIDEO_RST[`FLD_RAW12_BIT];
      autoload_block_q <= VIDEO_RST[`FLD_AUTOLOAD_BLOCK_BIT];
      lock_prev_q      <= 1'b0;
      load_pending_q   <= 1'b0;
    end else begin
      lock_prev_q <= rx_lock;
      if (!rx_lock || autoload) begin
        load_pending_q <= 1'b0;
      end else if (lock_rise) begin
        load_pending_q <= 1'b1;
      end
      if (wr_mode) begin
        ctl_rsv7_q <= reg_wdata[`FLD_MODE_RSV7_BIT];
        ctl_rsv5_q <= reg_wdata[`FLD_MODE_RSV5_BIT];
        override_q <= reg_wdata[`FLD_STRAP_OVERRIDE_BIT];
        // mode field writable only while override is already set
        if (override_q) begin
          reg_mode_q <= reg_wdata[`FLD_MODE_MSB:`FLD_MODE_LSB]; // R4
        end else begin
          reg_mode_q <= strap_mode_q; // R3
        end
      end else if (!override_q) begin
        // track the strap so enabling override starts from current mode
        reg_mode_q <= strap_mode_q; // R3
      end
      if (wr_video) begin
        video_rsv_q      <= reg_wdata[`FLD_VIDEO_RSV_MSB:`FLD_VIDEO_RSV_LSB];
        raw10_q          <= reg_wdata[`FLD_RAW10_BIT];
        raw12_q          <= reg_wdata[`FLD_RAW12_BIT];
        autoload_block_q <= reg_wdata[`FLD_AUTOLOAD_BLOCK_BIT]; // R11
      end else if (autoload) begin
        raw10_q <= bcc_raw10; // R8
        raw12_q <= bcc_raw12; // R9
      end
    end
  end

  // ------------------------------------------------------------
  // readback
  // ------------------------------------------------------------
  reg [7:0] rd_d;

  always @* begin
    rd_d = 8'h00;
    case (reg_addr)
      `OFS_OPERATING_MODE_SELECT: begin
        rd_d = {ctl_rsv7_q, strap_bit6_q, ctl_rsv5_q, override_q,
                done_q, cur_mode}; // R3
      end
      `OFS_BACK_CHANNEL_VIDEO: begin
        rd_d = {video_rsv_q, raw10_q, raw12_q, autoload_block_q};
      end
      default: rd_d = 8'h00;
    endcase
  end

  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      reg_rdata            <= 8'h00;
      reg_rvalid           <= 1'b0;
      operating_mode       <= 3'h0;
      mode_done            <= 1'b0;
      mode_reserved        <= 1'b0;
      local_clock_required <= 1'b0;
      raw10_video_select   <= 1'b0;
      raw12_video_select   <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd_en;
      if (reg_rd_en) begin
        reg_rdata <= rd_d;
      end
      operating_mode <= cur_mode; // R1
      mode_done      <= done_q; // R2
      // R6 R12: anything outside the four defined codes is flagged
      mode_reserved  <= ~((cur_mode == `MODE_CSI_SYNC) |
                          (cur_mode == `MODE_CSI_NONSYNC_EXT) |
                          (cur_mode == `MODE_CSI_NONSYNC_AON) |
                          (cur_mode == `MODE_VIDEO_EXT_CLK)); // R6 R12
      // R7: tells the system a local clock source is needed
      local_clock_required <= (cur_mode == `MODE_CSI_NONSYNC_EXT) |
                              (cur_mode == `MODE_VIDEO_EXT_CLK); // R7
      raw10_video_select   <= raw10_q; // R8
      raw12_video_select   <= raw12_q; // R9
    end
  end

endmodule // serializer_mode_select

`default_nettype wire

/* tb/mode_select_monitor.sv */
// concurrent checks on the mode select register bank ports
`default_nettype none
module mode_select_monitor (
  input wire logic       clk_sys,
  input wire logic       reset,
  input wire logic       powerdown_n_input,
  input wire logic       reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_rvalid,
  input wire logic [2:0] operating_mode,
  input wire logic       mode_done,
  input wire logic       mode_reserved,
  input wire logic       local_clock_required,
  input wire logic       raw10_video_select,
  input wire logic       raw12_video_select
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  a_read_answer: assert property (reg_rd_en |=> reg_rvalid)
    else $error("read not answered");
  a_answer_pulse: assert property (!reg_rd_en |=> !reg_rvalid)
    else $error("stray read answer");
  a_unmapped_zero: assert property (reg_rd_en && reg_addr > 8'h04
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  a_mode_readback: assert property (reg_rd_en && reg_addr == 8'h03
    |=> reg_rdata[2:0] == operating_mode) else $error("mode readback");
  a_clock_need: assert property ($stable(operating_mode) [*2] |->
    local_clock_required == (operating_mode inside {3'h2, 3'h5}))
    else $error("local clock flag wrong");
  a_reserved_flag: assert property ($stable(operating_mode) [*2] |->
    mode_reserved == (operating_mode inside {3'h1, 3'h4, 3'h6, 3'h7}))
    else $error("reserved flag wrong");
  a_done_cleared: assert property (!powerdown_n_input [*8] |->
    !mode_done) else $error("done held in powerdown");
  a_done_rises: assert property ($rose(powerdown_n_input) |->
    ##[9:40] mode_done) else $error("mode never settled");
  a_done_settle: assert property ($rose(mode_done) |->
    $past(powerdown_n_input, 8)) else $error("done too early");
  a_video_copy: assert property (reg_rd_en && reg_addr == 8'h04
    |=> reg_rdata[2:1] == {raw10_video_select, raw12_video_select})
    else $error("video outputs differ from register");
endmodule // mode_select_monitor

bind serializer_mode_select mode_select_monitor u_mon (
  .clk_sys(clk_sys), .reset(reset),
  .powerdown_n_input(powerdown_n_input), .reg_rd_en(reg_rd_en),
  .reg_addr(reg_addr), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .operating_mode(operating_mode), .mode_done(mode_done),
  .mode_reserved(mode_reserved),
  .local_clock_required(local_clock_required),
  .raw10_video_select(raw10_video_select),
  .raw12_video_select(raw12_video_select));
`default_nettype wire

/* tb/remote_deser_model.sv */
// far end of the control channel: lock and video bits to autoload
`default_nettype none
module remote_deser_model (
  input  wire logic clk_sys,
  input  wire logic link_up,
  input  wire logic want10,
  input  wire logic want12,
  output var  logic rx_lock,
  output var  logic bcc_video_valid,
  output var  logic bcc_raw10,
  output var  logic bcc_raw12
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {rx_lock, bcc_video_valid, bcc_raw10, bcc_raw12} = 4'h0;
  // valid lags lock a cycle; bits toggle while link_up is low, hold want10/want12 while high
  always @(posedge clk_sys) begin
    rx_lock <= link_up;
    bcc_video_valid <= link_up & rx_lock;
    bcc_raw10 <= link_up ? want10 : ~bcc_raw10;
    bcc_raw12 <= link_up ? want12 : ~bcc_raw12;
  end
endmodule // remote_deser_model
`default_nettype wire

/* tb/testbench.sv */
// self-checking bench for the mode select register bank
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys, reset, powerdown_n_input, mode_strap_bit6_pin;
  logic        reg_wr_en, reg_rd_en, reg_rvalid, link_up, want10, want12;
  logic        rx_lock, bcc_video_valid, bcc_raw10, bcc_raw12, mode_done;
  logic        mode_reserved, local_clock_required, r10, r12;
  logic [2:0]  mode_strap_pin, operating_mode;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, d;
  logic [31:0] rnd = 32'hacba_3e77;
  int          miscompares = 0, checked = 0, md, ov, r4, b6;

  serializer_mode_select u_dut (.clk_sys(clk_sys), .reset(reset),
    .powerdown_n_input(powerdown_n_input), .mode_strap_pin(mode_strap_pin),
    .mode_strap_bit6_pin(mode_strap_bit6_pin), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .rx_lock(rx_lock),
    .bcc_video_valid(bcc_video_valid), .bcc_raw10(bcc_raw10),
    .bcc_raw12(bcc_raw12), .operating_mode(operating_mode),
    .mode_done(mode_done), .mode_reserved(mode_reserved),
    .local_clock_required(local_clock_required),
    .raw10_video_select(r10), .raw12_video_select(r12));
  remote_deser_model u_far (.clk_sys(clk_sys), .link_up(link_up),
    .want10(want10), .want12(want12), .rx_lock(rx_lock),
    .bcc_video_valid(bcc_video_valid), .bcc_raw10(bcc_raw10),
    .bcc_raw12(bcc_raw12));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] exp_mode();
    return {1'b0, b6[0], 1'b0, ov[0], 1'b1, md[2:0]};
  endfunction
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr_en <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clk_sys);
    reg_rd_en <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd_en <= 1'b0;
    #1;
    chk({7'h0, reg_rvalid}, 8'h01);
    d = reg_rdata;
  endtask
  task wait_done;
    for (int i = 0; i < 50 && mode_done !== 1'b1; i++) @(posedge clk_sys);
    #1;
    if (mode_done !== 1'b1) begin
      miscompares++;
      stop_test;
    end
    chk({7'h0, mode_done}, 8'h01);
  endtask
  task relock(input logic w10, input logic w12);
    @(posedge clk_sys);
    link_up <= 1'b0;
    want10 <= w10;
    want12 <= w12;
    repeat (4) @(posedge clk_sys);
    link_up <= 1'b1;
    repeat (6) @(posedge clk_sys);
    rd(8'h04);
    chk(d, r4[7:0]);
    chk({6'h0, r10, r12}, {6'h0, r4[2:1]});
  endtask
  task stop_test;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  initial begin
    reset = 1'b1;
    powerdown_n_input = 1'b0;
    mode_strap_pin = 3'h2;
    mode_strap_bit6_pin = 1'b1;
    {reg_wr_en, reg_rd_en, link_up, want10, want12} = 5'b00010;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (4) @(posedge clk_sys);
    powerdown_n_input <= 1'b1;
    wait_done;
    ov = 0;
    md = 2;
    b6 = 1;
    rd(8'h03);
    chk(d, exp_mode());
    wr(8'h03, 8'h05);
    rd(8'h03);
    chk(d, exp_mode());
    wr(8'h03, 8'h13);
    ov = 1;
    rd(8'h03);
    chk(d, exp_mode());
    $display("strap capture and write lock done");
    for (int m = 0; m < 8; m++) begin
      md = m;
      wr(8'h03, 8'h10 | md[7:0]);
      rd(8'h03);
      chk(d, exp_mode());
      repeat (2) @(posedge clk_sys);
      chk({5'h0, operating_mode}, md[7:0]);
      chk({7'h0, mode_reserved}, md inside {1, 4, 6, 7});
      chk({7'h0, local_clock_required}, md == 2 || md == 5);
    end
    wr(8'h03, 8'h00);
    ov = 0;
    md = 2;
    repeat (8) @(posedge clk_sys);
    rd(8'h03);
    chk(d, exp_mode());
    wr(8'h07, 8'hff);
    rd(8'h07);
    chk(d, 8'h00);
    $display("override and unmapped done");
    r4 = 4;
    relock(1'b1, 1'b0);
    r4 = 2;
    relock(1'b0, 1'b1);
    rnd = lfsr(rnd);
    r4 = {rnd[4:0], 3'b101};
    wr(8'h04, r4[7:0]);
    relock(1'b0, 1'b1);
    $display("video autoload done");
    @(posedge clk_sys);
    powerdown_n_input <= 1'b0;
    mode_strap_pin <= 3'h3;
    mode_strap_bit6_pin <= 1'b0;
    repeat (10) @(posedge clk_sys);
    #1;
    chk({7'h0, mode_done}, 8'h00);
    @(posedge clk_sys);
    powerdown_n_input <= 1'b1;
    wait_done;
    md = 3;
    b6 = 0;
    rd(8'h03);
    chk(d, exp_mode());
    chk({5'h0, operating_mode}, 8'h03);
    $display("powerdown recapture done");
    stop_test;
  end
endmodule // testbench
`default_nettype wire
